// >>> sxl_top.v
// configuration latches, power-down control and lock detect of the synthesizer
//
// Notes on behaviour
// - divider word holds halved select, halving, gain, main, swallow, select 10.
// - reference word holds band divider, test, precision, antibacklash, divider, select 01.
// - select 00 words go into the control latch on load strobe rise.
// - first control write powers up; following divider write starts band selection.
// - power-up with unchanged divider relocks without new band selection.
// - primary set, sync select clear powers down at once.
// - both set powers down on second reference edge after strobe.
// - chip enable low disables the device regardless of power-down bits.
// - power-down loads counters, tristates pump, clears lock, mutes outputs, stops buffer.
// - serial register keeps shifting and latching in power-down.
// - low three current bits are setting one, high three setting two.
// - gain bit of the latest control (bit 10) or divider (bit 21) write picks setting two when 1, setting one when 0.
// - mute-until-locked keeps outputs off until lock is reported.
// - prescaler bits pick modulus, level bits pick output power.
// - 24 bits shifted msb first, copied on load strobe rise.
// - select 00 control, 01 reference, 10 divider, 11 test latch ignored.
// - lock after 3 (or 5) good cycles, cleared by large error.
// - band selection on divider update, or at power-up after a divider write while down, on divided reference clock.
`include "sxl_defs.vh"
module sxl_top #(
    parameter WORD_W = `SXL_WORD_W
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // serial write port
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        load_strobe,
    // chip enable pin, low disables
    input  wire        chip_en,
    // reference counter output and phase detector status
    input  wire        ref_out,
    input  wire        pfd_tick,
    input  wire        err_below_15ns,
    input  wire        err_above_25ns,
    // divider fields
    output reg         prescaler_input_halved_sel,
    output reg         output_halving_en,
    output reg  [12:0] main_counter,
    output reg  [4:0]  swallow_counter,
    // reference fields
    output reg  [1:0]  band_clk_div,
    output reg         factory_test_bit,
    output reg         lock_precision,
    output reg  [1:0]  antibacklash_width,
    output reg  [13:0] ref_divider,
    // control fields
    output reg  [1:0]  prescaler_sel,
    output reg  [1:0]  output_level,
    output reg         pump_gain_sel,
    output reg  [2:0]  pump_current,
    output reg  [7:0]  control_misc,
    // power and lock status
    output reg         powered_down,
    output reg         counters_load,
    output reg         pump_tristate,
    output reg         ref_buffer_en,
    output reg         rf_out_en,
    output reg         lock_detect,
    output reg         band_select_active
);
    wire [WORD_W-1:0] word;
    wire              word_valid;
    reg  [WORD_W-1:0] ctrl;
    reg               sw_pd;
    reg               sync_pend;
    reg  [1:0]        sync_edges;
    reg               ref_q;
    reg               tick_q;
    reg  [2:0]        good_cnt;
    reg               band_pend;
    reg  [2:0]        band_cnt;
    reg  [2:0]        band_pre;
    reg               locked;
    wire              pd_now;
    wire              ref_rise;
    wire              band_tick;
    wire [1:0]        sel;
    wire              wr_ctrl;
    wire              wr_ref;
    wire              wr_div;
    // one-cycle rise of a registered level
    function rise;
        input prev;
        input cur;
        begin
            rise = cur & ~prev;
        end
    endfunction
    // prescale mask for divide by 1, 2, 4 or 8
    function [2:0] div_mask;
        input [1:0] code;
        begin
            div_mask = (3'h1 << code) - 3'h1;
        end
    endfunction
    sxl_shift #(
        .WORD_W     (WORD_W)
    ) u_shift (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .ser_clk    (ser_clk),
        .ser_data   (ser_data),
        .load_strobe(load_strobe),
        .word       (word),
        .word_valid (word_valid)
    );
    // latch routing by the two low bits; test latch words are dropped
    assign sel     = word[1:0];
    assign wr_ctrl = word_valid && (sel == `SXL_SEL_CONTROL);
    assign wr_ref  = word_valid && (sel == `SXL_SEL_REFERENCE);
    assign wr_div  = word_valid && (sel == `SXL_SEL_DIVIDER);
    // chip enable overrides both power-down bits
    assign pd_now    = sw_pd | ~chip_en;
    assign ref_rise  = rise(ref_q, ref_out);
    assign band_tick = ref_rise && ((band_pre & div_mask(band_clk_div)) == 3'h0);
    // input edge history; divider and reference latches stay writable in power-down
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_q                      <= 1'b0;
            tick_q                     <= 1'b0;
            prescaler_input_halved_sel <= 1'b0;
            output_halving_en          <= 1'b0;
            main_counter               <= 13'h0000;
            swallow_counter            <= 5'h00;
            band_clk_div               <= 2'h0;
            factory_test_bit           <= 1'b0;
            lock_precision             <= 1'b0;
            antibacklash_width         <= 2'h0;
            ref_divider                <= 14'h0000;
            ctrl                       <= {WORD_W{1'b0}};
            pump_gain_sel              <= 1'b0;
        end
        else
        begin
            ref_q  <= ref_out;
            tick_q <= pfd_tick;
            if (wr_div)
            begin
                prescaler_input_halved_sel <= word[`SXL_N_HALVED_SEL];
                output_halving_en          <= word[`SXL_N_HALVING_EN];
                main_counter    <= word[`SXL_N_MAIN_HI:`SXL_N_MAIN_LO];
                swallow_counter <= word[`SXL_N_SWALLOW_HI:`SXL_N_SWALLOW_LO];
                pump_gain_sel   <= word[`SXL_N_GAIN];
            end
            if (wr_ref)
            begin
                band_clk_div       <= word[`SXL_R_BAND_HI:`SXL_R_BAND_LO];
                factory_test_bit   <= word[`SXL_R_TEST];
                lock_precision     <= word[`SXL_R_PRECISION];
                antibacklash_width <= word[`SXL_R_ABL_HI:`SXL_R_ABL_LO];
                ref_divider        <= word[`SXL_R_DIV_HI:`SXL_R_DIV_LO];
            end
            if (wr_ctrl)
            begin
                ctrl          <= word;
                pump_gain_sel <= word[`SXL_C_GAIN];
            end
        end
    end
    // software power-down; starts powered down until the first control word
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_pd      <= 1'b1;
            sync_pend  <= 1'b0;
            sync_edges <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            // clear primary powers up; a sync request while down is ignored
            sync_edges <= 2'h0;
            sw_pd      <= word[`SXL_C_PD_PRIMARY] & (~word[`SXL_C_PD_SYNC] | sw_pd);
            sync_pend  <= word[`SXL_C_PD_PRIMARY] & word[`SXL_C_PD_SYNC] & ~sw_pd;
        end
        else if (sync_pend && ref_rise)
        begin
            // gated by reference edges so the loop does not jump mid cycle
            if (sync_edges == `SXL_SYNC_PD_EDGES - 2'h1)
            begin
                sw_pd     <= 1'b1;
                sync_pend <= 1'b0;
            end
            sync_edges <= sync_edges + 2'h1;
        end
    end
    // band selection: a divider write while down waits for power-up
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            band_pend <= 1'b0;
            band_cnt  <= 3'h0;
            band_pre  <= 3'h0;
        end
        else
        begin
            if (ref_rise)
                band_pre <= band_pre + 3'h1;
            if (pd_now)
            begin
                band_cnt <= 3'h0;
                if (wr_div)
                    band_pend <= 1'b1;
            end
            else if (wr_div || band_pend)
            begin
                band_cnt  <= `SXL_BAND_CYCLES;
                band_pend <= 1'b0;
            end
            else if (band_tick && band_cnt != 3'h0)
                band_cnt <= band_cnt - 3'h1;
        end
    end
    // digital lock detect; unchanged divider lets it relock without band select
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_cnt <= 3'h0;
            locked   <= 1'b0;
        end
        else if (pd_now)
        begin
            good_cnt <= 3'h0;
            locked   <= 1'b0;
        end
        else if (rise(tick_q, pfd_tick))
        begin
            if (err_above_25ns)
            begin
                good_cnt <= 3'h0;
                locked   <= 1'b0;
            end
            else if (err_below_15ns)
            begin
                if (good_cnt != 3'h7)
                    good_cnt <= good_cnt + 3'h1;
                if (good_cnt + 3'h1 >= (lock_precision ? `SXL_LOCK_COUNT_PREC
                                                       : `SXL_LOCK_COUNT_STD))
                    locked <= 1'b1;
            end
            else
                good_cnt <= 3'h0;
        end
    end
    // registered outputs derived from latches and power state
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescaler_sel      <= 2'h0;
            output_level       <= 2'h0;
            pump_current       <= 3'h0;
            control_misc       <= 8'h00;
            powered_down       <= 1'b1;
            counters_load      <= 1'b1;
            pump_tristate      <= 1'b1;
            ref_buffer_en      <= 1'b0;
            rf_out_en          <= 1'b0;
            lock_detect        <= 1'b0;
            band_select_active <= 1'b0;
        end
        else
        begin
            prescaler_sel <= ctrl[`SXL_C_PRESC_HI:`SXL_C_PRESC_LO];
            output_level  <= ctrl[`SXL_C_LEVEL_HI:`SXL_C_LEVEL_LO];
            if (pump_gain_sel)
                pump_current <= ctrl[`SXL_C_CUR_TWO_HI:`SXL_C_CUR_TWO_LO];
            else
                pump_current <= ctrl[`SXL_C_CUR_ONE_HI:`SXL_C_CUR_ONE_LO];
            control_misc  <= ctrl[`SXL_C_MISC_HI:`SXL_C_MISC_LO];
            powered_down  <= pd_now;
            counters_load <= pd_now;
            pump_tristate <= pd_now | ctrl[`SXL_C_TRISTATE];
            ref_buffer_en <= ~pd_now;
            rf_out_en     <= ~pd_now & (~ctrl[`SXL_C_MUTE] | locked);
            lock_detect   <= locked & ~pd_now;
            band_select_active <= (band_cnt != 3'h0) & ~pd_now;
        end
    end
endmodule // sxl_top

// >>> sxl_defs.vh
// constants for the synthesizer configuration latch block
`ifndef SXL_DEFS_VH
`define SXL_DEFS_VH
`define SXL_WORD_W        24
`define SXL_SEL_CONTROL   2'h0
`define SXL_SEL_REFERENCE 2'h1
`define SXL_SEL_DIVIDER   2'h2
`define SXL_SEL_TEST      2'h3
// control word fields
`define SXL_C_PRESC_HI    23
`define SXL_C_PRESC_LO    22
`define SXL_C_PD_SYNC     21
`define SXL_C_PD_PRIMARY  20
`define SXL_C_CUR_TWO_HI  19
`define SXL_C_CUR_TWO_LO  17
`define SXL_C_CUR_ONE_HI  16
`define SXL_C_CUR_ONE_LO  14
`define SXL_C_LEVEL_HI    13
`define SXL_C_LEVEL_LO    12
`define SXL_C_MUTE        11
`define SXL_C_GAIN        10
`define SXL_C_TRISTATE    9
`define SXL_C_MISC_HI     9
`define SXL_C_MISC_LO     2
// divider word fields
`define SXL_N_HALVED_SEL  23
`define SXL_N_HALVING_EN  22
`define SXL_N_GAIN        21
`define SXL_N_MAIN_HI     20
`define SXL_N_MAIN_LO     8
`define SXL_N_SWALLOW_HI  6
`define SXL_N_SWALLOW_LO  2
// reference word fields
`define SXL_R_BAND_HI     21
`define SXL_R_BAND_LO     20
`define SXL_R_TEST        19
`define SXL_R_PRECISION   18
`define SXL_R_ABL_HI      17
`define SXL_R_ABL_LO      16
`define SXL_R_DIV_HI      15
`define SXL_R_DIV_LO      2
// timing counts in detector or reference cycles
`define SXL_LOCK_COUNT_STD   3'h3
`define SXL_LOCK_COUNT_PREC  3'h5
`define SXL_BAND_CYCLES      3'h5
`define SXL_SYNC_PD_EDGES    2'h2
`endif

// >>> sxl_shift.v
// serial input shift register with load strobe capture
`include "sxl_defs.vh"
module sxl_shift #(
    parameter WORD_W = `SXL_WORD_W
) (
    // clock and reset
    input  wire              mclk,
    input  wire              rst_n,
    // serial pins
    input  wire              ser_clk,
    input  wire              ser_data,
    input  wire              load_strobe,
    // captured word
    output reg  [WORD_W-1:0] word,
    output reg               word_valid
);
    reg              clk_q;
    reg              data_q;
    reg              strobe_q;
    reg              strobe_qq;
    reg              clk_qq;
    reg [WORD_W-1:0] shreg;

    // register pins once so edge and data line up in the same cycle
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_q     <= 1'b0;
            clk_qq    <= 1'b0;
            data_q    <= 1'b0;
            strobe_q  <= 1'b0;
            strobe_qq <= 1'b0;
        end
        else
        begin
            clk_q     <= ser_clk;
            clk_qq    <= clk_q;
            data_q    <= ser_data;
            strobe_q  <= load_strobe;
            strobe_qq <= strobe_q;
        end
    end

    // msb first shift, keeps running in power-down too
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shreg      <= {WORD_W{1'b0}};
            word       <= {WORD_W{1'b0}};
            word_valid <= 1'b0;
        end
        else
        begin
            word_valid <= 1'b0;
            if (clk_q && !clk_qq)
                shreg <= {shreg[WORD_W-2:0], data_q};
            if (strobe_q && !strobe_qq)
            begin
                word       <= shreg;
                word_valid <= 1'b1;
            end
        end
    end
endmodule // sxl_shift

// >>> sxl_sva.sv
// assertion checker for the synthesizer configuration latch block
module sxl_sva (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // pins
    input wire logic        load_strobe,
    input wire logic        chip_en,
    input wire logic        pfd_tick,
    input wire logic        err_below_15ns,
    input wire logic        err_above_25ns,
    // latch fields and status
    input wire logic        lock_precision,
    input wire logic [12:0] main_counter,
    input wire logic [13:0] ref_divider,
    input wire logic        powered_down,
    input wire logic        counters_load,
    input wire logic        pump_tristate,
    input wire logic        ref_buffer_en,
    input wire logic        rf_out_en,
    input wire logic        lock_detect
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ls_q;
    logic       ce_q;
    logic       tk_q;
    logic [2:0] age;
    logic [2:0] good;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // age since strobe or enable rise, and run of good detector cycles
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            {ls_q, ce_q, tk_q} <= 3'h2; // enable idles high, so no false rise after reset
            age <= 3'h7;
            good <= 3'h0;
        end
        else
        begin
            {ls_q, ce_q, tk_q} <= {load_strobe, chip_en, pfd_tick};
            if ((load_strobe & ~ls_q) | (chip_en & ~ce_q))
                age <= 3'h0;
            else if (age != 3'h7)
                age <= age + 3'h1;
            if (powered_down)
                good <= 3'h0;
            else if (pfd_tick & ~tk_q)
                good <= (err_below_15ns & ~err_above_25ns) ? good + {2'h0, good != 3'h7} : 3'h0;
        end
    sequence bad_tick_s;
        $rose(pfd_tick) && err_above_25ns;
    endsequence
    ce_low_a: assert property (!chip_en |-> ##[1:4] powered_down)
        else $error("chip enable low left device up");
    ce_hold_a: assert property (!chip_en [*4] |-> powered_down)
        else $error("device up while chip enable low");
    pd_load_a: assert property (powered_down [*2] |-> counters_load)
        else $error("counters not loaded in power-down");
    pd_quiet_a: assert property (powered_down [*2] |-> pump_tristate && !ref_buffer_en
        && !rf_out_en && !lock_detect) else $error("power-down left a path active");
    bad_tick_a: assert property (bad_tick_s |-> ##[1:4] !lock_detect)
        else $error("large phase error kept lock");
    lock_run_a: assert property ($rose(lock_detect) |->
        good >= (lock_precision ? 3'h5 : 3'h3)) else $error("lock set too early");
    field_cause_a: assert property (
        $changed(main_counter) || $changed(ref_divider) |-> age <= 3'h5)
        else $error("latch changed without strobe");
    wake_cause_a: assert property ($fell(powered_down) |-> age <= 3'h6)
        else $error("power-up without a write");
endmodule // sxl_sva

bind sxl_top sxl_sva sva_u (.mclk, .rst_n, .load_strobe, .chip_en, .pfd_tick, .err_below_15ns,
    .err_above_25ns, .lock_precision, .main_counter, .ref_divider, .powered_down, .counters_load,
    .pump_tristate, .ref_buffer_en, .rf_out_en, .lock_detect);

// >>> sxl_host.sv
// host model that shifts 24-bit words into the serial write port
module sxl_host (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // word request
    input  wire logic        start,
    input  wire logic [23:0] word,
    // serial pins and status
    output logic             ser_clk,
    output logic             ser_data,
    output logic             load_strobe,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] sh;
    logic [4:0]  nbit;
    logic [2:0]  ph;
    // eight mclk per bit keeps each serial clock phase above three mclk
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            {busy, ser_clk, ser_data, load_strobe} <= 4'h0;
            ph <= 3'h0;
            nbit <= 5'h0;
            sh <= 24'h0;
        end
        else if (!busy)
        begin
            load_strobe <= 1'h0;
            busy <= start;
            sh <= word;
            nbit <= 5'h18;
            ph <= 3'h0;
        end
        else
        begin
            ph <= ph + 3'h1;
            if (nbit != 5'h0)
                case (ph)
                    3'h0: ser_data <= sh[23]; // msb first
                    3'h1: ser_clk <= 1'h1;
                    3'h5: ser_clk <= 1'h0;
                    3'h7: {sh, nbit} <= {sh[22:0], 1'h0, nbit - 5'h1};
                    default: ;
                endcase
            else
                case (ph)
                    3'h0: ser_data <= ~ser_data; // released line must not hold a value
                    3'h2: load_strobe <= 1'h1; // copy after the 24th bit
                    3'h7: busy <= 1'h0;
                    default: ;
                endcase
        end
endmodule // sxl_host

// >>> test_synth_config_latches_powerdown.sv
// self-checking bench for the synthesizer configuration latch block
module test_synth_config_latches_powerdown;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, start = 0, chip_en = 1, ref_out = 0, pfd_tick = 0;
    logic err_below_15ns = 0, err_above_25ns = 0, band_seen = 0;
    logic ser_clk, ser_data, load_strobe, busy, prescaler_input_halved_sel, output_halving_en;
    logic factory_test_bit, lock_precision, pump_gain_sel, powered_down, counters_load;
    logic pump_tristate, ref_buffer_en, rf_out_en, lock_detect, band_select_active;
    logic [23:0] word = 24'h0;
    logic [12:0] main_counter;
    logic [4:0]  swallow_counter;
    logic [1:0]  band_clk_div, antibacklash_width, prescaler_sel, output_level;
    logic [13:0] ref_divider;
    logic [2:0]  pump_current;
    logic [7:0]  control_misc;
    int          failures = 0, samples_checked = 0, cycles = 0;
    sxl_host host_u (.mclk, .rst_n, .start, .word, .ser_clk, .ser_data, .load_strobe, .busy);
    sxl_top dut_u (.mclk, .rst_n, .ser_clk, .ser_data, .load_strobe, .chip_en, .ref_out,
        .pfd_tick, .err_below_15ns, .err_above_25ns, .prescaler_input_halved_sel,
        .output_halving_en, .main_counter, .swallow_counter, .band_clk_div, .factory_test_bit,
        .lock_precision, .antibacklash_width, .ref_divider, .prescaler_sel, .output_level,
        .pump_gain_sel, .pump_current, .control_misc, .powered_down, .counters_load,
        .pump_tristate, .ref_buffer_en, .rf_out_en, .lock_detect, .band_select_active);
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, run needs about 30000 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            final_report;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        #1;
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        int i;
        @(posedge mclk);
        word <= w;
        start <= 1'h1;
        @(posedge mclk);
        start <= 1'h0;
        @(posedge mclk);
        for (i = 0; i < 400 && busy; i++)
            @(posedge mclk);
        repeat (6) @(posedge mclk);
    endtask
    task automatic refe(input int n);
        repeat (n)
        begin
            @(posedge mclk) ref_out <= 1'h1;
            repeat (3) @(posedge mclk);
            ref_out <= 1'h0;
            repeat (3) @(posedge mclk);
            if (band_select_active === 1'h1)
                band_seen = 1;
        end
    endtask
    task automatic tk(input int n, input logic lo, input logic hi);
        repeat (n)
        begin
            @(posedge mclk);
            {err_below_15ns, err_above_25ns, pfd_tick} <= {lo, hi, 1'h1};
            repeat (3) @(posedge mclk);
            pfd_tick <= 1'h0;
            repeat (3) @(posedge mclk);
        end
    endtask
    // control word, reserved fields zero
    function automatic logic [23:0] cw(input logic s, input logic p);
        return {2'h2, s, p, 3'h2, 3'h5, 2'h3, 1'h1, 1'h0, 8'h00, 2'h0};
    endfunction
    task automatic t_ref;
        chk("powered_down", 1, powered_down);
        wr({2'h0, 2'h1, 1'h0, 1'h1, 2'h2, 14'h2A5B, 2'h1});
        chk("band_clk_div", 1, band_clk_div);
        chk("lock_precision", 1, lock_precision);
        chk("factory_test_bit", 0, factory_test_bit);
        chk("antibacklash_width", 2, antibacklash_width);
        chk("ref_divider", 14'h2A5B, ref_divider);
    endtask
    task automatic t_ctrl;
        wr(cw(0, 0));
        chk("powered_down", 0, powered_down);
        chk("prescaler_sel", 2, prescaler_sel);
        chk("output_level", 3, output_level);
        chk("pump_current", 5, pump_current);
        chk("rf_out_en", 0, rf_out_en);
        chk("pump_tristate", 0, pump_tristate);
        chk("control_misc", 8'h00, control_misc);
    endtask
    task automatic t_div;
        repeat (24000) @(posedge mclk);
        wr({1'h1, 1'h0, 1'h1, 13'h1234, 1'h0, 5'h15, 2'h2});
        chk("halved_sel", 1, prescaler_input_halved_sel);
        chk("output_halving_en", 0, output_halving_en);
        chk("main_counter", 13'h1234, main_counter);
        chk("swallow_counter", 5'h15, swallow_counter);
        chk("pump_current", 2, pump_current);
        refe(60);
        chk("band_seen", 1, band_seen);
        chk("band_select_active", 0, band_select_active);
    endtask
    task automatic t_lock;
        tk(4, 1, 0);
        chk("lock_detect", 0, lock_detect);
        tk(1, 1, 0);
        chk("lock_detect", 1, lock_detect);
        chk("rf_out_en", 1, rf_out_en);
        tk(1, 0, 1);
        chk("lock_detect", 0, lock_detect);
        tk(5, 1, 0);
    endtask
    task automatic t_apd;
        wr(cw(0, 1));
        chk("pump_tristate", 1, pump_tristate);
        chk("ref_buffer_en", 0, ref_buffer_en);
        chk("counters_load", 1, counters_load);
        chk("lock_detect", 0, lock_detect);
        chk("rf_out_en", 0, rf_out_en);
        wr({2'h0, 2'h1, 1'h0, 1'h1, 2'h2, 14'h0155, 2'h1});
        wr(24'hFFFFFF);
        chk("ref_divider", 14'h0155, ref_divider);
        wr(cw(0, 0));
        band_seen = 0;
        refe(40);
        chk("band_seen", 0, band_seen);
    endtask
    task automatic t_spd;
        wr(cw(1, 1));
        refe(1);
        chk("powered_down", 0, powered_down);
        refe(1);
        chk("powered_down", 1, powered_down);
        wr(cw(0, 0));
        @(posedge mclk) chip_en <= 1'h0;
        repeat (5) @(posedge mclk);
        chk("powered_down", 1, powered_down);
        @(posedge mclk) chip_en <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("powered_down", 0, powered_down);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        t_ref;
        t_ctrl;
        t_div;
        t_lock;
        t_apd;
        t_spd;
        repeat (8) @(posedge mclk);
        final_report;
    end
endmodule // test_synth_config_latches_powerdown
